// [sorter_pkg.sv]
// Constants shared by the sorter trigger and result port block.
// Assumes a 250 MHz core clock and an APB register bus with 32-bit data.
package sorter_pkg;
   localparam int unsigned CLK_MHZ        = 250;
   localparam int unsigned TRIG_MIN_US    = 10;
   localparam int unsigned TRIG_MIN_CYC   = TRIG_MIN_US * CLK_MHZ;
   localparam int unsigned MS_TICK_US     = 1000;
   localparam int unsigned MS_TICK_CYC    = MS_TICK_US * CLK_MHZ;
   localparam int unsigned CLEAR_MAX_MS   = 60000;
   localparam logic [7:0]  OFF_CTRL       = 8'h00;
   localparam logic [7:0]  OFF_DELAY      = 8'h04;
   localparam logic [7:0]  OFF_COMM       = 8'h08;
   localparam logic [7:0]  OFF_STATUS     = 8'h0C;
   localparam logic [7:0]  OFF_RESULT     = 8'h10;
   localparam logic [7:0]  OFF_CMD        = 8'h14;
   localparam logic [7:0]  OFF_UPDATE     = 8'h18;
   localparam logic [7:0]  OFF_PASSWORD   = 8'h1C;
   localparam int unsigned CTRL_EXT_BIT   = 0;
   localparam int unsigned CTRL_CMP_BIT   = 1;
   localparam int unsigned CTRL_CLEAR_BIT = 2;
   localparam int unsigned COMM_AUTO_BIT  = 3;
   localparam int unsigned COMM_MULTI_BIT = 4;
   localparam int unsigned CMD_READ_BIT   = 0;
   localparam int unsigned CMD_DFLT_BIT   = 1;
   localparam int unsigned UPD_START_BIT  = 0;
   localparam logic [2:0]  BAUD_1200      = 3'h0;
   localparam logic [2:0]  BAUD_9600      = 3'h1;
   localparam logic [2:0]  BAUD_19200     = 3'h2;
   localparam logic [2:0]  BAUD_38400     = 3'h3;
   localparam logic [2:0]  BAUD_115200    = 3'h4;
   localparam logic [4:0]  ADDR_DEFAULT   = 5'h08;
   localparam logic [23:0] PASSWORD_DFLT  = 24'h123456;
   localparam logic [15:0] DELAY_DEFAULT  = 16'h0000;
   localparam logic [2:0]  BAUD_DEFAULT   = BAUD_9600;
   typedef enum logic [1:0] {
      UPD_IDLE   = 2'b00,
      UPD_VERIFY = 2'b01,
      UPD_WRITE  = 2'b11,
      UPD_RESTART= 2'b10
   } upd_state_t;
endpackage

// [sorter_trigger_result_port.sv]
// Sorter port trigger, result output, remote result delivery and system settings.
// Assumes synchronous inputs, an APB master, and external engines for the flash and image check.
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - In external trigger mode a rising trigger edge from the coaxial input or sorter port starts a measurement.
// - With the comparator on, each measurement's bin result drives the sorter port.
// - In hold mode the sorter outputs stay until the next result replaces them.
// - In clear mode the sorter outputs drop once the programmed delay after driving has passed.
// - The clear delay takes 0 to 60 s and matters only in clear mode.
// - In query mode the last valid result enters the output buffer only on a host read command.
// - In automatic mode every completed result enters the output buffer.
// - The serial link offers exactly 1200, 9600, 19200, 38400 and 115200 bit/s.
// - The chosen rate drives both the serial link and the USB virtual serial port.
// - In multi-drop mode the station address 0 to 31 picks out traffic for this device.
// - A defaults reset restores all settings and the password, keeps the clock, and needs the right password.
// - A firmware image is verified before flashing, installed only if good, then the device restarts.
module sorter_trigger_result_port
   import sorter_pkg::*;
#(
   parameter int unsigned MS_CYCLES  = MS_TICK_CYC,
   parameter int unsigned BIN_WIDTH  = 4
) (
   input  wire logic                 core_clk,
   input  wire logic                 rst_n,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic                 coax_trigger,
   input  wire logic                 sorter_trigger,
   output logic                      meas_start,
   input  wire logic                 meas_done,
   input  wire logic                 meas_valid,
   input  wire logic [31:0]          meas_data,
   input  wire logic [BIN_WIDTH-1:0] meas_bin,
   output logic      [BIN_WIDTH-1:0] sorter_bin,
   output logic                      out_buf_load,
   output logic      [31:0]          out_buf_data,
   output logic      [2:0]           baud_select,
   output logic                      multi_drop_en,
   input  wire logic [4:0]           rx_frame_addr,
   input  wire logic                 rx_frame_valid,
   output logic                      rx_frame_accept,
   output logic                      image_check_start,
   input  wire logic                 image_check_done,
   input  wire logic                 image_check_ok,
   output logic                      flash_write_start,
   input  wire logic                 flash_write_done,
   output logic                      system_restart
);
   logic              ext_mode_q, cmp_en_q, clear_mode_q, auto_mode_q, multi_q;
   logic [15:0]       delay_ms_q;
   logic [2:0]        baud_q;
   logic [4:0]        station_q;
   logic [23:0]       password_q, pw_entry_q;
   logic              trig_prev_q;
   logic [31:0]       last_data_q;
   logic              last_valid_q;
   logic [BIN_WIDTH-1:0] bin_q;
   logic              buf_load_q;
   logic [31:0]       buf_data_q;
   logic [31:0]       tick_q;
   logic [15:0]       ms_left_q;
   logic              clr_armed_q;
   logic              upd_fail_q, dflt_fail_q;
   upd_state_t        upd_q;

   wire         trig_in     = coax_trigger | sorter_trigger;
   wire         wr_en       = psel & penable & pwrite;
   wire         rd_en       = psel & penable & ~pwrite;
   wire         hit_ctrl    = paddr == OFF_CTRL;
   wire         hit_delay   = paddr == OFF_DELAY;
   wire         hit_comm    = paddr == OFF_COMM;
   wire         hit_status  = paddr == OFF_STATUS;
   wire         hit_result  = paddr == OFF_RESULT;
   wire         hit_cmd     = paddr == OFF_CMD;
   wire         hit_update  = paddr == OFF_UPDATE;
   wire         hit_pw      = paddr == OFF_PASSWORD;
   wire         mapped      = hit_ctrl | hit_delay | hit_comm | hit_status |
                              hit_result | hit_cmd | hit_update | hit_pw;
   wire         baud_ok     = pwdata[2:0] <= BAUD_115200;
   wire         delay_ok    = pwdata[15:0] <= 16'(CLEAR_MAX_MS);
   wire         bad_value   = (hit_comm & ~baud_ok) | (hit_delay & ~delay_ok);
   wire         wr_ok       = wr_en & mapped & ~bad_value;
   wire         read_cmd    = wr_ok & hit_cmd & pwdata[CMD_READ_BIT];
   wire         dflt_cmd    = wr_ok & hit_cmd & pwdata[CMD_DFLT_BIT];
   wire         pw_match    = pw_entry_q == password_q;
   wire         do_default  = dflt_cmd & pw_match;
   wire         trig_rise   = ext_mode_q & trig_in & ~trig_prev_q;
   wire         new_result  = meas_done & cmp_en_q;
   wire         tick_end    = tick_q == MS_CYCLES - 1;
   wire         clr_expire  = clear_mode_q & clr_armed_q & (ms_left_q == 16'h0000);
   wire         upd_start   = wr_ok & hit_update & pwdata[UPD_START_BIT] & (upd_q == UPD_IDLE);

   assign pready          = 1'b1;
   assign pslverr         = psel & penable & (~mapped | (pwrite & bad_value));
   assign meas_start      = trig_rise;
   assign sorter_bin      = bin_q;
   assign out_buf_load    = buf_load_q;
   assign out_buf_data    = buf_data_q;
   assign baud_select     = baud_q;
   assign multi_drop_en   = multi_q;
   assign rx_frame_accept = rx_frame_valid & (~multi_q | (rx_frame_addr == station_q));
   assign image_check_start = upd_q == UPD_VERIFY;
   assign flash_write_start = upd_q == UPD_WRITE;
   assign system_restart    = upd_q == UPD_RESTART;

   always_comb begin
      prdata = 32'h0000_0000;
      if (rd_en) begin
         case (1'b1)
            hit_ctrl:   prdata = {29'h0, clear_mode_q, cmp_en_q, ext_mode_q};
            hit_delay:  prdata = {16'h0, delay_ms_q};
            hit_comm:   prdata = {11'h0, station_q, 11'h0, multi_q, auto_mode_q, baud_q};
            hit_status: prdata = {25'h0, dflt_fail_q, upd_fail_q, upd_q, clr_armed_q, last_valid_q, 1'b0}
                                 | 32'(bin_q) << 8;
            hit_result: prdata = last_data_q;
            default:    prdata = 32'h0000_0000;
         endcase
      end
   end

   // Settings registers; a defaults reset leaves any time-of-day logic alone since none lives here.
   always_ff @(posedge core_clk) begin
      if (!rst_n || do_default) begin
         ext_mode_q   <= 1'b0;
         cmp_en_q     <= 1'b0;
         clear_mode_q <= 1'b0;
         delay_ms_q   <= DELAY_DEFAULT;
         baud_q       <= BAUD_DEFAULT;
         auto_mode_q  <= 1'b0;
         multi_q      <= 1'b0;
         station_q    <= ADDR_DEFAULT;
         password_q   <= PASSWORD_DFLT;
      end else if (wr_ok) begin
         if (hit_ctrl) begin
            ext_mode_q   <= pwdata[CTRL_EXT_BIT];
            cmp_en_q     <= pwdata[CTRL_CMP_BIT];
            clear_mode_q <= pwdata[CTRL_CLEAR_BIT];
         end
         if (hit_delay) delay_ms_q <= pwdata[15:0];
         if (hit_comm) begin
            baud_q      <= pwdata[2:0];
            auto_mode_q <= pwdata[COMM_AUTO_BIT];
            multi_q     <= pwdata[COMM_MULTI_BIT];
            station_q   <= pwdata[20:16];
         end
         if (hit_pw && pw_match && pwdata[31]) password_q <= pwdata[23:0];
      end
   end

   // Password entry is written first; a mismatch refuses the defaults reset and flags it.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pw_entry_q  <= 24'h000000;
         dflt_fail_q <= 1'b0;
      end else begin
         if (wr_ok && hit_pw && !pwdata[31]) pw_entry_q <= pwdata[23:0];
         if (dflt_cmd) dflt_fail_q <= ~pw_match;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         trig_prev_q  <= 1'b0;
         last_data_q  <= 32'h0000_0000;
         last_valid_q <= 1'b0;
      end else begin
         trig_prev_q <= trig_in;
         if (meas_done && meas_valid) begin
            last_data_q  <= meas_data;
            last_valid_q <= 1'b1;
         end
      end
   end

   // Output buffer load; automatic mode wins when a read command collides with a result.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         buf_load_q <= 1'b0;
         buf_data_q <= 32'h0000_0000;
      end else begin
         buf_load_q <= 1'b0;
         if (auto_mode_q && meas_done) begin
            buf_load_q <= 1'b1;
            buf_data_q <= meas_data;
         end else if (!auto_mode_q && read_cmd && last_valid_q) begin
            buf_load_q <= 1'b1;
            buf_data_q <= last_data_q;
         end
      end
   end

   // Sorter outputs and the millisecond clear timer.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         bin_q       <= '0;
         tick_q      <= 32'h0000_0000;
         ms_left_q   <= 16'h0000;
         clr_armed_q <= 1'b0;
      end else if (new_result) begin
         bin_q       <= meas_bin;
         tick_q      <= 32'h0000_0000;
         ms_left_q   <= delay_ms_q;
         clr_armed_q <= 1'b1;
      end else if (clr_expire) begin
         bin_q       <= '0;
         clr_armed_q <= 1'b0;
      end else if (clear_mode_q && clr_armed_q) begin
         tick_q <= tick_end ? 32'h0000_0000 : tick_q + 32'h0000_0001;
         if (tick_end) ms_left_q <= ms_left_q - 16'h0001;
      end
   end

   // Firmware update walk; the flash is never touched unless the image check passed.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         upd_q      <= UPD_IDLE;
         upd_fail_q <= 1'b0;
      end else begin
         case (upd_q)
            UPD_IDLE: if (upd_start) begin
               upd_q      <= UPD_VERIFY;
               upd_fail_q <= 1'b0;
            end
            UPD_VERIFY: if (image_check_done) begin
               upd_q      <= image_check_ok ? UPD_WRITE : UPD_IDLE;
               upd_fail_q <= ~image_check_ok;
            end
            UPD_WRITE: if (flash_write_done) upd_q <= UPD_RESTART;
            UPD_RESTART: upd_q <= UPD_IDLE;
            default: upd_q <= UPD_IDLE;
         endcase
      end
   end

   a_trig_rise_only: assert property (@(posedge core_clk) disable iff (!rst_n)
      meas_start |-> ext_mode_q && $rose(trig_in)) else $error("start without rising trigger");
   a_bin_on_result: assert property (@(posedge core_clk) disable iff (!rst_n)
      new_result |=> sorter_bin == $past(meas_bin)) else $error("sorter bin not loaded");
   a_hold_keeps: assert property (@(posedge core_clk) disable iff (!rst_n)
      !clear_mode_q && !new_result && !do_default |=> $stable(sorter_bin)) else $error("hold output changed");
   a_clear_drops: assert property (@(posedge core_clk) disable iff (!rst_n)
      clr_expire && !new_result |=> sorter_bin == '0) else $error("clear did not drop");
   a_delay_range: assert property (@(posedge core_clk) disable iff (!rst_n)
      delay_ms_q <= 16'(CLEAR_MAX_MS)) else $error("delay out of range");
   a_query_load: assert property (@(posedge core_clk) disable iff (!rst_n)
      !auto_mode_q && !meas_done |=> out_buf_load == $past(read_cmd && last_valid_q)) else $error("query load wrong");
   a_auto_load: assert property (@(posedge core_clk) disable iff (!rst_n)
      auto_mode_q && meas_done |=> out_buf_load && out_buf_data == $past(meas_data)) else $error("auto load missing");
   a_baud_legal: assert property (@(posedge core_clk) disable iff (!rst_n)
      baud_select <= BAUD_115200) else $error("illegal baud");
   a_addr_filter: assert property (@(posedge core_clk) disable iff (!rst_n)
      rx_frame_accept && multi_q |-> rx_frame_addr == station_q) else $error("foreign frame accepted");
   a_default_pw: assert property (@(posedge core_clk) disable iff (!rst_n)
      dflt_cmd && !pw_match |=> dflt_fail_q) else $error("bad password not refused");
   a_flash_checked: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(flash_write_start) |-> $past(image_check_done && image_check_ok)) else $error("flash before check");

   // A broken down-counter would hide behind hold mode, so the clear timer is pinned down step by step.
   a_trig_needs_ext: assert property (@(posedge core_clk) disable iff (!rst_n)
      !ext_mode_q |-> !meas_start) else $error("start outside external trigger mode");
   a_bin_not_early: assert property (@(posedge core_clk) disable iff (!rst_n)
      clr_armed_q && (ms_left_q != 16'h0000) && !new_result |=> $stable(sorter_bin))
      else $error("sorter bin dropped before the delay ran out");
   a_ms_countdown: assert property (@(posedge core_clk) disable iff (!rst_n)
      clear_mode_q && clr_armed_q && !clr_expire && !new_result && tick_end
      |=> ms_left_q == $past(ms_left_q) - 16'h0001) else $error("clear delay did not count down");
   a_delay_hold_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
      !clear_mode_q && !new_result |=> $stable(ms_left_q) && $stable(tick_q)) else $error("timer ran in hold mode");
   a_delay_refused: assert property (@(posedge core_clk) disable iff (!rst_n)
      wr_en && hit_delay && !delay_ok |-> pslverr ##1 $stable(delay_ms_q)) else $error("illegal delay taken");
   a_query_data: assert property (@(posedge core_clk) disable iff (!rst_n)
      !auto_mode_q && read_cmd && last_valid_q |=> out_buf_load && out_buf_data == $past(last_data_q))
      else $error("query result wrong");
   a_baud_refused: assert property (@(posedge core_clk) disable iff (!rst_n)
      wr_en && hit_comm && !baud_ok |-> pslverr ##1 $stable(baud_select)) else $error("illegal baud taken");
   a_addr_pass: assert property (@(posedge core_clk) disable iff (!rst_n)
      rx_frame_valid && (!multi_q || rx_frame_addr == station_q) |-> rx_frame_accept)
      else $error("own frame dropped");
   a_default_restore: assert property (@(posedge core_clk) disable iff (!rst_n)
      do_default |=> baud_select == BAUD_DEFAULT && delay_ms_q == DELAY_DEFAULT && !multi_drop_en &&
      station_q == ADDR_DEFAULT && password_q == PASSWORD_DFLT) else $error("defaults not restored");
   a_default_kept: assert property (@(posedge core_clk) disable iff (!rst_n)
      dflt_cmd && !pw_match |=> $stable(baud_select) && $stable(password_q))
      else $error("settings lost without password");
   a_fail_no_flash: assert property (@(posedge core_clk) disable iff (!rst_n)
      upd_q == UPD_VERIFY && image_check_done && !image_check_ok |=> upd_q == UPD_IDLE && upd_fail_q)
      else $error("failed image not refused");
   a_restart_once: assert property (@(posedge core_clk) disable iff (!rst_n)
      flash_write_start && flash_write_done |=> system_restart ##1 !system_restart) else $error("restart missing");
   a_clear_restart: assert property (@(posedge core_clk) disable iff (!rst_n)
      clear_mode_q && new_result |=> clr_armed_q && ms_left_q == $past(delay_ms_q) && tick_q == 32'h0000_0000)
      else $error("clear delay not restarted");
endmodule
`default_nettype wire

// [sorter_far_side_model.sv]
// Parts sorter_port model: sends trigger pulses on the coaxial input or the sorter port.
// Assumes the bench requests a pulse with a one-cycle fire strobe after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module sorter_far_side_model #(
   parameter int unsigned PULSE_CYC = 16
) (
   input  wire logic core_clk,
   input  wire logic fire_coax,
   input  wire logic fire_port,
   output logic      coax_trigger,
   output logic      sorter_trigger
);
   int unsigned cnt_q = 0;
   logic        port_q = 1'b0;
   // Requests during a pulse are dropped so that every pulse keeps its full width.
   always @(posedge core_clk) begin
      if (cnt_q != 0) begin
         cnt_q <= cnt_q - 1;
      end else if (fire_coax || fire_port) begin
         cnt_q  <= PULSE_CYC;
         port_q <= fire_port;
      end
   end
   assign coax_trigger   = (cnt_q != 0) && !port_q;
   assign sorter_trigger = (cnt_q != 0) && port_q;
endmodule
`default_nettype wire

// [sorter_trigger_result_port_bench.sv]
// Self-checking bench for the sorter trigger and result port block.
// Assumes the package and the far-side model are compiled first; the millisecond tick is shortened.
`timescale 1ns/1ps
`default_nettype none
module sorter_trigger_result_port_bench;
   import sorter_pkg::*;
   localparam int unsigned PW = TRIG_MIN_CYC + 4;
   logic        core_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, meas_data = 32'h0, seed = 32'hED4E8562, prdata, out_buf_data, rv;
   logic        pready, pslverr, coax_trigger, sorter_trigger, meas_start, out_buf_load, multi_drop_en;
   logic        meas_done = 1'b0, meas_valid = 1'b0, rx_frame_valid = 1'b0, rx_frame_accept, image_check_start;
   logic        image_check_done = 1'b0, image_check_ok = 1'b0, flash_write_start, flash_write_done = 1'b0;
   logic        system_restart, er, fire_coax = 1'b0, fire_port = 1'b0;
   logic [3:0]  meas_bin = 4'h0, sorter_bin;
   logic [2:0]  baud_select;
   logic [4:0]  rx_frame_addr = 5'h00;
   logic [31:0] exp_q[$];
   int          n_fail = 0, samples_checked = 0, n_start = 0, n_rst = 0;

   always #2 core_clk = ~core_clk;

   sorter_trigger_result_port #(.MS_CYCLES(10), .BIN_WIDTH(4)) sorter_trigger_result_port_inst (
      .core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .coax_trigger, .sorter_trigger, .meas_start, .meas_done, .meas_valid, .meas_data, .meas_bin,
      .sorter_bin, .out_buf_load, .out_buf_data, .baud_select, .multi_drop_en, .rx_frame_addr,
      .rx_frame_valid, .rx_frame_accept, .image_check_start, .image_check_done, .image_check_ok,
      .flash_write_start, .flash_write_done, .system_restart);

   sorter_far_side_model #(.PULSE_CYC(PW)) sorter_far_side_model_inst (
      .core_clk, .fire_coax, .fire_port, .coax_trigger, .sorter_trigger);

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // The request is held until pready is seen high, so a slower slave needs no change here.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rv = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(negedge core_clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
      apb(1'b1, a, d);
      chk("pslverr", {31'h0, e}, {31'h0, er});
   endtask

   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rv);
   endtask

   task automatic fire(input logic p);
      @(posedge core_clk);
      fire_coax <= !p;
      fire_port <= p;
      @(posedge core_clk);
      fire_coax <= 1'b0;
      fire_port <= 1'b0;
      repeat (PW + 8) @(posedge core_clk);
   endtask

   task automatic meas(input logic [3:0] b, input logic auto_on);
      seed = lfsr(seed);
      @(posedge core_clk);
      meas_done  <= 1'b1;
      meas_valid <= 1'b1;
      meas_bin   <= b;
      meas_data  <= seed;
      if (auto_on) exp_q.push_back(seed);
      @(posedge core_clk);
      meas_done <= 1'b0;
      repeat (2) @(posedge core_clk);
   endtask

   always @(posedge core_clk) begin
      if (meas_start === 1'b1) n_start++;
      if (system_restart === 1'b1) n_rst++;
      if (out_buf_load === 1'b1) begin
         if (exp_q.size() == 0) chk("out_buf_load", 32'h0, 32'h1);
         else chk("out_buf_data", exp_q.pop_front(), out_buf_data);
      end
   end

   initial begin
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      rd("comm_reset", OFF_COMM, 32'h00080001);
      rd("ctrl_reset", OFF_CTRL, 32'h0);
      for (int i = 0; i < 6; i++) begin
         wr(OFF_COMM, 32'h00080000 | 32'(i), i > 4);
         chk("baud_select", (i > 4) ? 32'h4 : 32'(i), {29'h0, baud_select});
      end
      wr(OFF_DELAY, 32'h0000EA60, 1'b0);
      wr(OFF_DELAY, 32'h0000EA61, 1'b1);
      rd("delay", OFF_DELAY, 32'h0000EA60);
      fire(1'b0);
      chk("meas_start", 32'h0, 32'(n_start));
      wr(OFF_CTRL, 32'h3, 1'b0);
      fire(1'b0);
      fire(1'b1);
      chk("meas_start", 32'h2, 32'(n_start));
      meas(4'h5, 1'b0);
      chk("sorter_bin", 32'h5, {28'h0, sorter_bin});
      repeat (60) @(posedge core_clk);
      chk("sorter_bin", 32'h5, {28'h0, sorter_bin});
      meas(4'h9, 1'b0);
      chk("sorter_bin", 32'h9, {28'h0, sorter_bin});
      wr(OFF_DELAY, 32'h2, 1'b0);
      wr(OFF_CTRL, 32'h7, 1'b0);
      meas(4'h3, 1'b0);
      repeat (10) @(posedge core_clk);
      meas(4'h6, 1'b0);
      repeat (14) @(posedge core_clk);
      chk("sorter_bin", 32'h6, {28'h0, sorter_bin});
      repeat (12) @(posedge core_clk);
      chk("sorter_bin", 32'h0, {28'h0, sorter_bin});
      wr(OFF_COMM, 32'h00080009, 1'b0);
      meas(4'h1, 1'b1);
      meas(4'h2, 1'b1);
      wr(OFF_COMM, 32'h00080001, 1'b0);
      meas(4'h3, 1'b0);
      exp_q.push_back(meas_data);
      wr(OFF_CMD, 32'h1, 1'b0);
      repeat (4) @(posedge core_clk);
      chk("queue_left", 32'h0, 32'(exp_q.size()));
      rd("result", OFF_RESULT, meas_data);
      wr(OFF_COMM, 32'h00030011, 1'b0);
      chk("multi_drop_en", 32'h1, {31'h0, multi_drop_en});
      for (int a = 3; a < 5; a++) begin
         @(posedge core_clk);
         rx_frame_valid <= 1'b1;
         rx_frame_addr  <= 5'(a);
         @(negedge core_clk);
         chk("rx_frame_accept", 32'(a == 3), {31'h0, rx_frame_accept});
      end
      wr(OFF_PASSWORD, 32'h000000AA, 1'b0);
      wr(OFF_CMD, 32'h2, 1'b0);
      rd("comm_kept", OFF_COMM, 32'h00030011);
      wr(OFF_PASSWORD, 32'h00123456, 1'b0);
      wr(OFF_CMD, 32'h2, 1'b0);
      rd("comm_default", OFF_COMM, 32'h00080001);
      rd("delay_default", OFF_DELAY, 32'h0);
      apb(1'b0, 8'h20, 32'h0);
      chk("pslverr_unmapped", 32'h1, {31'h0, er});
      // The first image fails its check and must never reach flash; the second passes.
      for (int k = 0; k < 2; k++) begin
         wr(OFF_UPDATE, 32'h1, 1'b0);
         chk("image_check_start", 32'h1, {31'h0, image_check_start});
         @(posedge core_clk);
         image_check_ok   <= k[0];
         image_check_done <= 1'b1;
         @(posedge core_clk);
         image_check_done <= 1'b0;
         repeat (2) @(posedge core_clk);
         chk("flash_write_start", 32'(k), {31'h0, flash_write_start});
         chk("system_restart", 32'h0, 32'(n_rst));
      end
      rd("status_writing", OFF_STATUS, 32'h0000001A);
      @(posedge core_clk);
      flash_write_done <= 1'b1;
      @(posedge core_clk);
      flash_write_done <= 1'b0;
      repeat (4) @(posedge core_clk);
      chk("system_restart", 32'h1, 32'(n_rst));
      report_and_stop();
   end

   initial begin
      repeat (40000) @(posedge core_clk);
      n_fail++;
      report_and_stop();
   end
endmodule
`default_nettype wire
